// ==== mac_coprocessor_datapath_test.sv ====
// Purpose: Self-checking bench for the co-processor datapath
// Assumes: Memory words are byte-swapped addresses
// Notes: Reads and move writes share one queue of expectations
`timescale 1ns/1ps
module mac_coprocessor_datapath_test;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic instr_valid_in = 1'b0;
    logic [15:0] instr_word_in = 16'h0000;
    logic [15:0] reg_rdata_out, mem_addr_a_out, mem_addr_b_out, bus_a, bus_b, ia, gb, a, b;
    logic [15:0] mem_wr_addr_out, mem_wr_data_out, expq[$];
    logic instr_ready_out, mem_rd_out, mem_wr_out, trap_req_out, rd_d = 1'b0;
    logic [39:0] acc;
    int failures = 0, num_checks = 0, seed = 32'h37CADD38, n;
    initial forever #2.5 clk_in = ~clk_in;
    mcd_datapath u_mcd_datapath (.clk_in, .srst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .instr_valid_in, .instr_word_in, .instr_ready_out,
        .irq_break_in(1'b0), .mem_rd_out, .mem_addr_a_out, .mem_addr_b_out,
        .operand_bus_a_in(bus_a), .operand_bus_b_in(bus_b), .mem_wr_out, .mem_wr_addr_out,
        .mem_wr_data_out, .trap_req_out);
    mcd_mem_model u_mcd_mem_model (.clk_in, .mem_rd_in(mem_rd_out), .addr_a_in(mem_addr_a_out),
        .addr_b_in(mem_addr_b_out), .bus_a_out(bus_a), .bus_b_out(bus_b));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // A read notes its expected word before the strobe
    task automatic bus(input logic w, input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk_in);
        if (!w) expq.push_back(d);
        reg_addr_in <= ad;
        reg_wdata_in <= d;
        reg_wr_in <= w;
        reg_rd_in <= !w;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
    endtask : bus
    task automatic ins(input logic [15:0] w1, input logic [15:0] w2);
        @(posedge clk_in);
        instr_valid_in <= 1'b1;
        instr_word_in <= w1;
        @(posedge clk_in);
        instr_word_in <= w2;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (instr_ready_out !== 1'b1 && n < 9);
        if (instr_ready_out !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask : ins
    always @(posedge clk_in) begin
        rd_d <= reg_rd_in;
        if (rd_d) check(reg_rdata_out, expq.pop_front());
        if (mem_wr_out === 1'b1) begin
            check(mem_wr_addr_out, expq.pop_front());
            check(mem_wr_data_out, expq.pop_front());
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        bus(0, mcd_pkg::OFF_STATUS, 16'h0000);
        bus(0, mcd_pkg::OFF_CONTROL, 16'h0000);
        bus(0, mcd_pkg::OFF_ACC_HI, 16'h0000);
        bus(0, 4'hF, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            ia = 16'($random(seed)) & 16'h03FE;
            gb = 16'($random(seed)) & 16'hFFFE;
            bus(1, mcd_pkg::OFF_CONTROL, {15'h0000, ia[1]});
            bus(1, mcd_pkg::OFF_INDEX_POINTER_ZERO, ia);
            bus(1, mcd_pkg::OFF_GPR, gb);
            ins(16'h0031, 16'h0012);
            a = {ia[7:0], 8'hFA + {6'h00, ia[9:8]}};
            b = {gb[7:0], gb[15:8]};
            acc = 40'($signed(a) * $signed(b)) << ia[1];
            bus(0, mcd_pkg::OFF_ACC_HI, acc[31:16]);
            bus(0, mcd_pkg::OFF_ACC_LO, acc[15:0]);
            bus(0, mcd_pkg::OFF_INDEX_POINTER_ZERO, ia + 16'h0002);
            bus(0, mcd_pkg::OFF_GPR, gb - 16'h0002);
        end
        for (int i = 0; i < 2; i++) begin
            bus(1, mcd_pkg::OFF_CONTROL, 16'h0002);
            bus(1, mcd_pkg::OFF_INDEX_POINTER_ZERO, i ? 16'h0080 : 16'h0040);
            bus(1, mcd_pkg::OFF_GPR, 16'h0000);
            ins(16'h0086, 16'h0000);
            bus(0, mcd_pkg::OFF_ACC_HI, i ? 16'h8000 : 16'h7FFF);
            bus(0, mcd_pkg::OFF_ACC_LO, i ? 16'h0000 : 16'hFFFF);
            bus(0, mcd_pkg::OFF_STATUS, i ? 16'h04FF : 16'h0400);
            bus(1, mcd_pkg::OFF_STATUS, i ? 16'h00FF : 16'h0000);
            bus(0, mcd_pkg::OFF_STATUS, i ? 16'h00FF : 16'h0000);
        end
        bus(1, mcd_pkg::OFF_INDEX_POINTER_ZERO, 16'h0100);
        expq.push_back(16'hFAFE);
        expq.push_back(16'h00FB);
        ins(16'h0003, 16'h0010);
        bus(0, mcd_pkg::OFF_INDEX_POINTER_ZERO, 16'h0102);
        bus(1, mcd_pkg::OFF_REPEAT, 16'h0001);
        ins(16'h0041, 16'h0010);
        bus(0, mcd_pkg::OFF_INDEX_POINTER_ZERO, 16'h0106);
        give_verdict();
    end
endmodule : mac_coprocessor_datapath_test

// ==== mcd_datapath.sv ====
// Purpose: Multiply-accumulate co-processor datapath with address generation
// Assumes: Inputs synchronous to clk_in; memory answers in the decode cycle
// Notes: One instruction at a time; instr_ready_out paces the pipeline
// Function
// - Two memory operands are delivered in every instruction cycle.
// - Every co-processor operation executes in two cycles.
// - Each instruction is taken as two instruction words.
// - Decode addresses and post-modifies; execute updates; writeback stores move.
// - General register plus index pointer; index limited to dual-port RAM except in move.
// - Index pointer modifies by none, +2, -2, +offset, -offset.
// - General pointer 0-15 modifies by none, +2, -2, +offset, -offset.
// - Parallel move only in multiply-accumulate-with-move, double indirect.
// - Parallel move write address is the inverse of the index modification; plain move writes at the general pointer.
// - Multiply two 16-bit operands signed or unsigned into 32 bits.
// - Product sign-extended, shifted left one in fractional mode.
// - Adder input A: zero, round, product, or concatenated operand buses.
// - Adder input B: accumulator, shifted or inverted, or zero.
// - Extension flag set when the top eight bits carry significance.
// - Saturation clamps a 32-bit overflow to the most positive/negative value.
// - Each saturation sets the sticky limit flag until software clears it.
// - A 40-bit overflow sets the sticky overflow flag.
// - Instructions repeat up to 8192 times; an interrupt can break in.
// - Condition flags raise a class B trap request.
// - Accumulator is high word, low word and extension byte.
// - Rounding adds one at bit 15 then clears the low word.
// - A repeat count of N executes the instruction N+1 times.
`timescale 1ns/1ps
module mcd_datapath (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    output logic instr_ready_out,
    input wire logic irq_break_in,
    output logic mem_rd_out,
    output logic [15:0] mem_addr_a_out,
    output logic [15:0] mem_addr_b_out,
    input wire logic [15:0] operand_bus_a_in,
    input wire logic [15:0] operand_bus_b_in,
    output logic mem_wr_out,
    output logic [15:0] mem_wr_addr_out,
    output logic [15:0] mem_wr_data_out,
    output logic trap_req_out
);
    typedef struct packed {
        mcd_pkg::mcd_state_e state;
        logic [15:0] word1;
        logic [15:0] word2;
        logic [15:0][15:0] gpr;
        logic [15:0] index_pointer_zero;
        logic [15:0] index_pointer_one;
        logic [15:0] gpr_offset_zero;
        logic [15:0] gpr_offset_one;
        logic [15:0] index_offset_zero;
        logic [15:0] index_offset_one;
        logic [15:0] accum_high_word;
        logic [15:0] accum_low_word;
        logic [7:0] accum_extension_byte;
        logic ext_flag;
        logic sticky_overflow_flag;
        logic sticky_limit_flag;
        logic trap_flag;
        logic [7:0] coproc_control_word;
        logic repeat_flag;
        logic [12:0] repeat_count;
        logic [15:0] op_a;
        logic [15:0] op_b;
        logic [15:0] gpr_new;
        logic [15:0] move_addr;
        logic mem_wr;
        logic [15:0] mem_wr_addr;
        logic [15:0] mem_wr_data;
        logic [15:0] rdata;
    } mcd_regs_s;

    mcd_regs_s st_reg;
    mcd_regs_s st_next;

    logic [3:0] op;
    logic [3:0] gpr_sel;
    logic idx_sel;
    logic [15:0] idx_ptr;
    logic [15:0] idx_next;
    logic [15:0] idx_inv;
    logic [15:0] gpr_next;
    logic [15:0] idx_q;
    logic [15:0] gpr_q;
    logic [39:0] product;
    logic [39:0] acc;
    logic [39:0] concat;
    logic [39:0] add_a;
    logic [39:0] add_b;
    logic add_cin;
    logic [40:0] sum;
    logic [39:0] result;
    logic ovf32;
    logic ovf40;
    logic do_sat;
    logic acc_op;

    // First word: op, operand signs, repeat, concat shift, general register
    assign op = st_reg.word1[3:0];
    assign gpr_sel = st_reg.word1[11:8];
    assign idx_sel = st_reg.word2[8];
    assign idx_ptr = idx_sel ? st_reg.index_pointer_one : st_reg.index_pointer_zero;
    assign idx_q = st_reg.word2[7] ? st_reg.index_offset_one : st_reg.index_offset_zero;
    assign gpr_q = st_reg.word2[3] ? st_reg.gpr_offset_one : st_reg.gpr_offset_zero;
    assign acc = {st_reg.accum_extension_byte, st_reg.accum_high_word, st_reg.accum_low_word};
    assign concat = {{8{st_reg.op_a[15]}}, st_reg.op_a, st_reg.op_b};
    assign acc_op = (op != mcd_pkg::OP_NOP) && (op != mcd_pkg::OP_MOVE);

    mcd_ptr_mod u_idx_mod (
        .ptr_in(idx_ptr),
        .offset_in(idx_q),
        .code_in(st_reg.word2[6:4]),
        .next_ptr_out(idx_next),
        .inv_addr_out(idx_inv)
    );

    mcd_ptr_mod u_gpr_mod (
        .ptr_in(st_reg.gpr[gpr_sel]),
        .offset_in(gpr_q),
        .code_in(st_reg.word2[2:0]),
        .next_ptr_out(gpr_next),
        .inv_addr_out()
    );

    mcd_mul_scale u_mul (
        .op_a_in(st_reg.op_a),
        .op_b_in(st_reg.op_b),
        .signed_a_in(st_reg.word1[4]),
        .signed_b_in(st_reg.word1[5]),
        .frac_in(st_reg.coproc_control_word[mcd_pkg::CW_FRAC]),
        .product_out(product)
    );

    always_comb begin
        add_a = mcd_pkg::ACC_ZERO;
        add_b = mcd_pkg::ACC_ZERO;
        add_cin = 1'b0;
        unique case (op)
            mcd_pkg::OP_MUL: add_a = product;
            mcd_pkg::OP_MAC, mcd_pkg::OP_MACM: begin
                add_a = product;
                add_b = acc;
            end
            mcd_pkg::OP_ADD32: begin
                add_a = st_reg.word1[7] ? {concat[38:0], 1'b0} : concat;
                add_b = acc;
            end
            mcd_pkg::OP_SUB32: begin
                // Concatenation minus accumulator through the inverted path
                add_a = st_reg.word1[7] ? {concat[38:0], 1'b0} : concat;
                add_b = ~acc;
                add_cin = 1'b1;
            end
            mcd_pkg::OP_LOAD32: add_a = st_reg.word1[7] ? {concat[38:0], 1'b0} : concat;
            mcd_pkg::OP_ROUND: begin
                add_a = mcd_pkg::ACC_ROUND;
                add_b = acc;
            end
            mcd_pkg::OP_SHL: add_b = {acc[38:0], 1'b0};
            default: begin
                add_a = mcd_pkg::ACC_ZERO;
                add_b = mcd_pkg::ACC_ZERO;
            end
        endcase
        sum = {add_a[39], add_a} + {add_b[39], add_b} + {40'h00_0000_0000, add_cin};
        // sign of 41-bit sum disagrees with bit 39
        ovf40 = sum[40] ^ sum[39];
        // top nine bits not all sign
        ovf32 = (sum[39:31] != 9'h000) && (sum[39:31] != 9'h1FF);
        do_sat = st_reg.coproc_control_word[mcd_pkg::CW_SAT] && (ovf32 || ovf40);
        if (do_sat) begin
            result = sum[40] ? mcd_pkg::ACC_SAT_NEG : mcd_pkg::ACC_SAT_POS;
        end else begin
            result = sum[39:0];
        end
        // clear the low word after the round add
        if (op == mcd_pkg::OP_ROUND) begin
            result[15:0] = mcd_pkg::WORD_ZERO;
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.mem_wr = 1'b0;
        mem_rd_out = 1'b0;
        // general pointer reaches all memory, index only dual-port RAM except in move
        mem_addr_a_out = (op == mcd_pkg::OP_MOVE) ? idx_ptr
                       : (mcd_pkg::DPRAM_BASE + (idx_ptr & mcd_pkg::DPRAM_MASK));
        mem_addr_b_out = st_reg.gpr[gpr_sel];
        instr_ready_out = (st_reg.state == mcd_pkg::MCD_FETCH1)
                        || (st_reg.state == mcd_pkg::MCD_FETCH2);

        if (reg_wr_in) begin
            unique case (reg_addr_in)
                mcd_pkg::OFF_STATUS: begin
                    // Software clears sticky flags by writing zero
                    st_next.accum_extension_byte = reg_wdata_in[7:0];
                    st_next.ext_flag = reg_wdata_in[mcd_pkg::ST_EXT];
                    st_next.sticky_overflow_flag = reg_wdata_in[mcd_pkg::ST_SV];
                    st_next.sticky_limit_flag = reg_wdata_in[mcd_pkg::ST_SL];
                    st_next.trap_flag = reg_wdata_in[mcd_pkg::ST_TRAP];
                end
                mcd_pkg::OFF_CONTROL: st_next.coproc_control_word = reg_wdata_in[7:0];
                mcd_pkg::OFF_REPEAT: begin
                    st_next.repeat_flag = reg_wdata_in[mcd_pkg::RW_FLAG];
                    st_next.repeat_count = reg_wdata_in[12:0];
                end
                mcd_pkg::OFF_INDEX_POINTER_ZERO: st_next.index_pointer_zero = reg_wdata_in;
                mcd_pkg::OFF_INDEX_POINTER_ONE: st_next.index_pointer_one = reg_wdata_in;
                mcd_pkg::OFF_QR0: st_next.gpr_offset_zero = reg_wdata_in;
                mcd_pkg::OFF_QR1: st_next.gpr_offset_one = reg_wdata_in;
                mcd_pkg::OFF_QX0: st_next.index_offset_zero = reg_wdata_in;
                mcd_pkg::OFF_QX1: st_next.index_offset_one = reg_wdata_in;
                mcd_pkg::OFF_ACC_HI: st_next.accum_high_word = reg_wdata_in;
                mcd_pkg::OFF_ACC_LO: st_next.accum_low_word = reg_wdata_in;
                // General register selected by the pending first word
                mcd_pkg::OFF_GPR: st_next.gpr[gpr_sel] = reg_wdata_in;
                default: st_next.rdata = st_reg.rdata;
            endcase
        end

        unique case (st_reg.state)
            mcd_pkg::MCD_FETCH1: begin
                if (instr_valid_in) begin
                    st_next.word1 = instr_word_in;
                    st_next.state = mcd_pkg::MCD_FETCH2;
                end
            end
            mcd_pkg::MCD_FETCH2: begin
                if (instr_valid_in) begin
                    st_next.word2 = instr_word_in;
                    st_next.state = mcd_pkg::MCD_DECODE;
                end
            end
            mcd_pkg::MCD_DECODE: begin
                mem_rd_out = 1'b1;
                st_next.op_a = operand_bus_a_in;
                st_next.op_b = operand_bus_b_in;
                st_next.move_addr = mcd_pkg::DPRAM_BASE + (idx_inv & mcd_pkg::DPRAM_MASK);
                st_next.gpr_new = gpr_next;
                if (idx_sel) begin
                    st_next.index_pointer_one = idx_next;
                end else begin
                    st_next.index_pointer_zero = idx_next;
                end
                st_next.state = mcd_pkg::MCD_EXEC;
            end
            // execute and update at cycle end
            mcd_pkg::MCD_EXEC: begin
                st_next.gpr[gpr_sel] = st_reg.gpr_new;
                if (acc_op) begin
                    st_next.accum_extension_byte = result[39:32];
                    st_next.accum_high_word = result[31:16];
                    st_next.accum_low_word = result[15:0];
                    st_next.ext_flag = (result[39:31] != 9'h000) && (result[39:31] != 9'h1FF);
                    if (do_sat) begin
                        st_next.sticky_limit_flag = 1'b1;
                    end
                    if (ovf40) begin
                        st_next.sticky_overflow_flag = 1'b1;
                    end
                end
                // parallel move at the inverse address; plain move at the general pointer
                if (op == mcd_pkg::OP_MACM) begin
                    st_next.mem_wr = 1'b1;
                    st_next.mem_wr_addr = st_reg.move_addr;
                    st_next.mem_wr_data = st_reg.op_a;
                end else if (op == mcd_pkg::OP_MOVE) begin
                    st_next.mem_wr = 1'b1;
                    st_next.mem_wr_addr = st_reg.gpr[gpr_sel];
                    st_next.mem_wr_data = st_reg.op_a;
                end
                st_next.state = mcd_pkg::MCD_HOLD;
            end
            mcd_pkg::MCD_HOLD: begin
                // Count N left means N more passes
                if (st_reg.word1[6] && !irq_break_in
                        && st_reg.repeat_count != 13'h0000) begin
                    st_next.repeat_flag = 1'b1;
                    st_next.repeat_count = st_reg.repeat_count - 13'h0001;
                    st_next.state = mcd_pkg::MCD_DECODE;
                end else begin
                    // An interrupt leaves the flag set with the remaining count
                    if (!irq_break_in) begin
                        st_next.repeat_flag = 1'b0;
                    end
                    st_next.state = mcd_pkg::MCD_FETCH1;
                end
            end
            default: st_next.state = mcd_pkg::MCD_FETCH1;
        endcase

        // trap request from masked condition flags
        if (st_reg.coproc_control_word[mcd_pkg::CW_TRAP_EN]
                && ((st_next.ext_flag && st_reg.coproc_control_word[mcd_pkg::CW_EXT_MASK])
                || (st_next.sticky_overflow_flag && st_reg.coproc_control_word[mcd_pkg::CW_SV_MASK])
                || (st_next.sticky_limit_flag && st_reg.coproc_control_word[mcd_pkg::CW_SL_MASK])))
        begin
            st_next.trap_flag = 1'b1;
        end

        st_next.rdata = mcd_pkg::WORD_ZERO;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                mcd_pkg::OFF_STATUS: st_next.rdata = {4'h0, st_reg.trap_flag,
                    st_reg.sticky_limit_flag, st_reg.sticky_overflow_flag, st_reg.ext_flag,
                    st_reg.accum_extension_byte};
                mcd_pkg::OFF_CONTROL: st_next.rdata = {8'h00, st_reg.coproc_control_word};
                mcd_pkg::OFF_REPEAT: st_next.rdata = {st_reg.repeat_flag, 2'b00,
                    st_reg.repeat_count};
                mcd_pkg::OFF_INDEX_POINTER_ZERO: st_next.rdata = st_reg.index_pointer_zero;
                mcd_pkg::OFF_INDEX_POINTER_ONE: st_next.rdata = st_reg.index_pointer_one;
                mcd_pkg::OFF_QR0: st_next.rdata = st_reg.gpr_offset_zero;
                mcd_pkg::OFF_QR1: st_next.rdata = st_reg.gpr_offset_one;
                mcd_pkg::OFF_QX0: st_next.rdata = st_reg.index_offset_zero;
                mcd_pkg::OFF_QX1: st_next.rdata = st_reg.index_offset_one;
                mcd_pkg::OFF_ACC_HI: st_next.rdata = st_reg.accum_high_word;
                mcd_pkg::OFF_ACC_LO: st_next.rdata = st_reg.accum_low_word;
                mcd_pkg::OFF_GPR: st_next.rdata = st_reg.gpr[gpr_sel];
                default: st_next.rdata = mcd_pkg::WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_reg <= '0;
            st_reg.state <= mcd_pkg::MCD_FETCH1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out = st_reg.rdata;
    assign mem_wr_out = st_reg.mem_wr;
    assign mem_wr_addr_out = st_reg.mem_wr_addr;
    assign mem_wr_data_out = st_reg.mem_wr_data;
    assign trap_req_out = st_reg.trap_flag;
endmodule : mcd_datapath

// ==== mcd_datapath_chk.sv ====
// Purpose: Port-level checks of the co-processor datapath
// Assumes: One clock, synchronous active-high reset
// Notes: Repeat iterations re-enter decode from hold, not from fetch
`timescale 1ns/1ps
module mcd_datapath_chk (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic instr_ready_out,
    input wire logic mem_rd_out,
    input wire logic [15:0] mem_addr_a_out,
    input wire logic mem_wr_out,
    input wire logic trap_req_out
);
    wire [3:0] op_w = instr_word_in[3:0];
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    property p_rst; $fell(srst_in) |-> instr_ready_out && !mem_rd_out && !mem_wr_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    property p_pair; mem_rd_out && $past(instr_ready_out) |-> $past(instr_valid_in, 2)
        && $past(instr_ready_out, 2) && $past(instr_valid_in); endproperty
    a_pair: assert property (p_pair) else $error("decode without two words");
    property p_two; mem_rd_out |=> !instr_ready_out && !mem_rd_out ##1 !instr_ready_out
        ##1 (instr_ready_out || mem_rd_out); endproperty
    a_two: assert property (p_two) else $error("operation not two cycles");
    property p_wb; mem_wr_out |-> $past(mem_rd_out, 2); endproperty
    a_wb: assert property (p_wb) else $error("move write not in writeback");
    property p_wrp; mem_wr_out |=> !mem_wr_out; endproperty
    a_wrp: assert property (p_wrp) else $error("move write longer than one cycle");
    property p_win; mem_rd_out && $past(instr_ready_out) && $past(op_w, 2) != mcd_pkg::OP_MOVE
        |-> mem_addr_a_out - mcd_pkg::DPRAM_BASE <= mcd_pkg::DPRAM_MASK; endproperty
    a_win: assert property (p_win) else $error("index address outside window");
    property p_excl; instr_ready_out |-> !mem_rd_out && !mem_wr_out; endproperty
    a_excl: assert property (p_excl) else $error("memory access while fetching");
    property p_rdz; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
endmodule : mcd_datapath_chk
bind mcd_datapath mcd_datapath_chk u_chk (.clk_in, .srst_in, .reg_rd_in, .reg_rdata_out,
    .instr_valid_in, .instr_word_in, .instr_ready_out, .mem_rd_out, .mem_addr_a_out,
    .mem_wr_out, .trap_req_out);

// ==== mcd_mem_model.sv ====
// Purpose: Far-side memory answering the two operand fetches
// Assumes: Each word holds its own address byte-swapped
// Notes: Buses show the inverted last word outside fetches
`timescale 1ns/1ps
module mcd_mem_model (
    input wire logic clk_in,
    input wire logic mem_rd_in,
    input wire logic [15:0] addr_a_in,
    input wire logic [15:0] addr_b_in,
    output logic [15:0] bus_a_out,
    output logic [15:0] bus_b_out
);
    logic [15:0] last_a = 16'h0000;
    logic [15:0] last_b = 16'h0000;
    assign bus_a_out = mem_rd_in ? {addr_a_in[7:0], addr_a_in[15:8]} : ~last_a;
    assign bus_b_out = mem_rd_in ? {addr_b_in[7:0], addr_b_in[15:8]} : ~last_b;
    always @(posedge clk_in) begin
        last_a <= bus_a_out;
        last_b <= bus_b_out;
    end
endmodule : mcd_mem_model

// ==== mcd_mul_scale.sv ====
// Purpose: 16x16 signed/unsigned multiplier with one-bit fractional scaler
// Assumes: Operands are the two operand-bus words registered in decode
// Notes: Output is the sign-extended 40-bit adder operand
`timescale 1ns/1ps
module mcd_mul_scale (
    input wire logic [15:0] op_a_in,
    input wire logic [15:0] op_b_in,
    input wire logic signed_a_in,
    input wire logic signed_b_in,
    input wire logic frac_in,
    output logic [39:0] product_out
);
    logic signed [16:0] ext_a;
    logic signed [16:0] ext_b;
    logic signed [33:0] prod;
    logic [39:0] prod_ext;
    always_comb begin
        ext_a = $signed({signed_a_in & op_a_in[15], op_a_in});
        ext_b = $signed({signed_b_in & op_b_in[15], op_b_in});
        prod = ext_a * ext_b;
        // 17x17 keeps an unsigned 32-bit product positive
        prod_ext = {{6{prod[33]}}, prod};
        // Drop the redundant sign bit of a signed fraction
        product_out = frac_in ? {prod_ext[38:0], 1'b0} : prod_ext;
    end
endmodule : mcd_mul_scale

// ==== mcd_pkg.sv ====
// Purpose: Shared constants and types for the multiply-accumulate datapath
// Assumes: 16-bit CPU core, one clock, synchronous active-high reset
// Notes: Register offsets are word indices on the plain register port
package mcd_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_CONTROL = 4'h1;
    localparam logic [3:0] OFF_REPEAT = 4'h2;
    localparam logic [3:0] OFF_INDEX_POINTER_ZERO = 4'h3;
    localparam logic [3:0] OFF_INDEX_POINTER_ONE = 4'h4;
    localparam logic [3:0] OFF_QR0 = 4'h5;
    localparam logic [3:0] OFF_QR1 = 4'h6;
    localparam logic [3:0] OFF_QX0 = 4'h7;
    localparam logic [3:0] OFF_QX1 = 4'h8;
    localparam logic [3:0] OFF_ACC_HI = 4'h9;
    localparam logic [3:0] OFF_ACC_LO = 4'hA;
    localparam logic [3:0] OFF_GPR = 4'hB;
    // Status word fields
    localparam int unsigned ST_EXT = 8;
    localparam int unsigned ST_SV = 9;
    localparam int unsigned ST_SL = 10;
    localparam int unsigned ST_TRAP = 11;
    // Control word fields
    localparam int unsigned CW_FRAC = 0;
    localparam int unsigned CW_SAT = 1;
    localparam int unsigned CW_TRAP_EN = 4;
    localparam int unsigned CW_EXT_MASK = 5;
    localparam int unsigned CW_SV_MASK = 6;
    localparam int unsigned CW_SL_MASK = 7;
    // Repeat word fields
    localparam int unsigned RW_FLAG = 15;
    localparam int unsigned RW_CNT_W = 13;
    // Pointer post-modification codes
    localparam logic [2:0] PM_NONE = 3'h0;
    localparam logic [2:0] PM_INC2 = 3'h1;
    localparam logic [2:0] PM_DEC2 = 3'h2;
    localparam logic [2:0] PM_ADDQ = 3'h3;
    localparam logic [2:0] PM_SUBQ = 3'h4;
    localparam logic [15:0] PTR_STEP = 16'h0002;
    // Index addresses stay inside the dual-port RAM window except in move
    localparam logic [15:0] DPRAM_BASE = 16'hFA00;
    localparam logic [15:0] DPRAM_MASK = 16'h03FF;
    // Operation codes, first instruction word bits 3:0
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_MUL = 4'h1;
    localparam logic [3:0] OP_MAC = 4'h2;
    localparam logic [3:0] OP_MACM = 4'h3;
    localparam logic [3:0] OP_ADD32 = 4'h4;
    localparam logic [3:0] OP_SUB32 = 4'h5;
    localparam logic [3:0] OP_LOAD32 = 4'h6;
    localparam logic [3:0] OP_ROUND = 4'h7;
    localparam logic [3:0] OP_SHL = 4'h8;
    localparam logic [3:0] OP_MOVE = 4'h9;
    // Accumulator constants
    localparam logic [39:0] ACC_ZERO = 40'h00_0000_0000;
    localparam logic [39:0] ACC_ROUND = 40'h00_0000_8000;
    localparam logic [39:0] ACC_SAT_POS = 40'h00_7FFF_FFFF;
    localparam logic [39:0] ACC_SAT_NEG = 40'hFF_8000_0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    typedef enum logic [4:0] {
        MCD_FETCH1 = 5'b00001,
        MCD_FETCH2 = 5'b00010,
        MCD_DECODE = 5'b00100,
        MCD_EXEC = 5'b01000,
        MCD_HOLD = 5'b10000
    } mcd_state_e;
endpackage : mcd_pkg

// ==== mcd_ptr_mod.sv ====
// Purpose: Pointer post-modification and inverse write-back address
// Assumes: Codes from mcd_pkg; arithmetic wraps at 16 bits
// Notes: Used once for the index pointer and once for the general pointer
`timescale 1ns/1ps
module mcd_ptr_mod (
    input wire logic [15:0] ptr_in,
    input wire logic [15:0] offset_in,
    input wire logic [2:0] code_in,
    output logic [15:0] next_ptr_out,
    output logic [15:0] inv_addr_out
);
    always_comb begin
        next_ptr_out = ptr_in;
        inv_addr_out = ptr_in;
        unique case (code_in)
            mcd_pkg::PM_INC2: begin
                next_ptr_out = ptr_in + mcd_pkg::PTR_STEP;
                inv_addr_out = ptr_in - mcd_pkg::PTR_STEP;
            end
            mcd_pkg::PM_DEC2: begin
                next_ptr_out = ptr_in - mcd_pkg::PTR_STEP;
                inv_addr_out = ptr_in + mcd_pkg::PTR_STEP;
            end
            mcd_pkg::PM_ADDQ: begin
                next_ptr_out = ptr_in + offset_in;
                inv_addr_out = ptr_in - offset_in;
            end
            mcd_pkg::PM_SUBQ: begin
                next_ptr_out = ptr_in - offset_in;
                inv_addr_out = ptr_in + offset_in;
            end
            default: begin
                next_ptr_out = ptr_in;
                inv_addr_out = ptr_in;
            end
        endcase
    end
endmodule : mcd_ptr_mod
